/* File: rtl/sff_filter.sv */
// Symmetric systolic FIR filter with output buffer.
// Assumes upstream and downstream logic on i_core_clk.
// Function
// - Output is weighted sum of recent samples
// - Mirrored samples combined before one multiply
// - Weights signed fixed point, cw>=2, fw<cw
// - Samples signed, sample_width at least two
// - Without rounding, drop fraction bits
// - Rounding adds half, or just under for negatives
// - Saturation clamps to width limits
// - Without saturation, keep low bits only
// - Negated pairs subtract mirrored sample
// - Zero weights skip arithmetic, same result
// - Even or odd tap count, centre alone
// - Systolic chain of registered multiply-add stages
// - Capture and advance only on enabled edges
// - Even latency: half taps plus stages plus four
// - Odd latency: half order plus stages plus six
// - Rounding adds two cycles, saturation one
`timescale 1ns/100ps

// ==========================================================
// Output buffer, bypasses storage when empty
module sff_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,       // Core clock
    input  wire logic             i_rst,       // Sync reset
    input  wire logic             i_in_valid,  // Push request
    input  wire logic [WIDTH-1:0] i_in_data,   // Push data
    output logic                  o_in_ready,  // Room for a push
    output logic                  o_out_valid, // Head valid
    output logic      [WIDTH-1:0] o_out_data,  // Head data
    input  wire logic             i_out_ready  // Head taken
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             load_out;
    logic             push;
    logic             mem_push;
    logic             mem_pop;

    always_comb begin
        load_out = !o_out_valid || i_out_ready;
        push     = i_in_valid && o_in_ready;
        mem_pop  = load_out && (count_q != '0);
        mem_push = push && !(load_out && !mem_pop);
        count_d  = count_q;
        if (mem_push && !mem_pop) begin
            count_d = count_q + 1'b1;
        end else if (mem_pop && !mem_push) begin
            count_d = count_q - 1'b1;
        end
    end

    // Pointers wrap naturally, depth is a power of two
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            o_in_ready <= 1'b1;
        end else begin
            wr_ptr_q   <= mem_push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q   <= mem_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
            count_q    <= count_d;
            o_in_ready <= count_d < DEPTH;
        end
    end

    always_ff @(posedge i_clk) begin
        if (mem_push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_out_valid <= 1'b0;
            o_out_data  <= '0;
        end else if (load_out) begin
            o_out_valid <= mem_pop || push;
            o_out_data  <= mem_pop ? mem_q[rd_ptr_q] : i_in_data;
        end
    end

    fifo_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
        count_q <= DEPTH && (o_in_ready == (count_q < DEPTH)))
        else $error("buffer count out of range");
    head_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
        else $error("buffer head changed while stalled");
endmodule : sff_fifo

// ==========================================================
// One systolic multiply-add stage
module sff_mac_stage #(
    parameter logic signed [sff_pkg::COEF_TOTAL_BITS-1:0] COEF = '0,
    parameter bit CENTRE = 1'b0
) (
    input  wire logic                                    i_clk,  // Core clock
    input  wire logic                                    i_rst,  // Sync reset
    input  wire logic                                    i_adv,  // Pipeline advance
    input  wire logic signed [sff_pkg::SAMPLE_WIDTH-1:0] i_head, // Near sample
    input  wire logic signed [sff_pkg::SAMPLE_WIDTH-1:0] i_tail, // Mirrored sample
    input  wire logic signed [sff_pkg::ACC_W-1:0]        i_acc,  // Upstream sum
    output logic signed      [sff_pkg::ACC_W-1:0]        o_acc   // Sum out
);
    localparam int  PRE_W  = sff_pkg::PRE_W;
    localparam int  PROD_W = sff_pkg::PROD_W;
    localparam int  ACC_W  = sff_pkg::ACC_W;
    localparam bit  NEG    = sff_pkg::NEGATED_PAIRS_OPTION;
    localparam bit  SKIP   = sff_pkg::SKIP_NULL_TAPS_OPTION && (COEF == '0);

    logic signed [PRE_W-1:0]  pre_q;
    logic signed [PRE_W-1:0]  pre_d;
    logic signed [PROD_W-1:0] prod;

    always_comb begin
        if (CENTRE) begin
            pre_d = PRE_W'(i_head);
        end else if (NEG) begin
            pre_d = i_head - i_tail;
        end else begin
            pre_d = i_head + i_tail;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pre_q <= '0;
        end else if (i_adv) begin
            pre_q <= pre_d;
        end
    end

    if (SKIP) begin : g_null
        assign prod = '0;
    end else begin : g_mult
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                prod <= '0;
            end else if (i_adv) begin
                prod <= pre_q * COEF;
            end
        end

        mac_sum_a: assert property (@(posedge i_clk) disable iff (i_rst)
            i_adv ##1 i_adv |=> o_acc == $past(i_acc) + ACC_W'($past(pre_q, 2) * COEF))
            else $error("stage sum does not match weighted sample");
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_acc <= '0;
        end else if (i_adv) begin
            o_acc <= i_acc + ACC_W'(prod);
        end
    end
    pre_add_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_adv |=> pre_q == (CENTRE ? $past(i_head)
                           : NEG ? $past(i_head) - $past(i_tail)
                           : $past(i_head) + $past(i_tail)))
        else $error("pair combination wrong");
    null_tap_a: assert property (@(posedge i_clk) disable iff (i_rst)
        SKIP && i_adv |=> o_acc == $past(i_acc))
        else $error("null tap altered the sum");
endmodule : sff_mac_stage

// ==========================================================
// Filter top
module sff_filter (
    input  wire logic                                    i_core_clk, // Core clock
    input  wire logic                                    i_rst,      // Sync reset
    input  wire logic                                    i_en,       // Sample enable
    input  wire logic signed [sff_pkg::SAMPLE_WIDTH-1:0] i_x,        // Input sample
    output logic                                         o_ready,    // Input accepted
    output logic signed      [sff_pkg::SAMPLE_WIDTH-1:0] o_y,        // Output sample
    output logic                                         o_y_valid,  // Output valid
    input  wire logic                                    i_y_ready   // Output taken
);
    localparam int SW      = sff_pkg::SAMPLE_WIDTH;
    localparam int FW      = sff_pkg::COEF_FRACTION_BITS;
    localparam int ACC_W   = sff_pkg::ACC_W;
    localparam int ORDER   = sff_pkg::ORDER;
    localparam int STAGES  = sff_pkg::STAGES;
    localparam int PAD_LEN = sff_pkg::PAD_LEN;
    localparam int LATENCY = sff_pkg::LATENCY;
    localparam int FILL_W  = $clog2(LATENCY + 1);

    logic signed [SW-1:0]    smp_q [ORDER+1];
    logic signed [SW-1:0]    pad_q [PAD_LEN];
    logic signed [ACC_W-1:0] acc [STAGES+1];
    logic signed [ACC_W-1:0] acc_last;
    logic signed [ACC_W-1:0] red;
    logic signed [SW-1:0]    y_red;
    logic [FILL_W-1:0]       fill_q;
    logic                    adv;
    logic                    push;
    sff_pkg::sff_beat_type   beat;

    // ==========================================================
    // Advance only when enabled and the buffer has room
    assign adv      = i_en && o_ready;
    assign push     = adv && (fill_q == FILL_W'(LATENCY));
    assign acc[0]   = '0;
    assign acc_last = acc[STAGES];

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            smp_q <= '{default: '0};
        end else if (adv) begin
            smp_q[0] <= i_x;
            for (int i = 1; i <= ORDER; i++) begin
                smp_q[i] <= smp_q[i-1];
            end
        end
    end

    // ==========================================================
    // Systolic chain; tail sample is common to all stages
    for (genvar k = 0; k < STAGES; k++) begin : g_stage
        sff_mac_stage #(
            .COEF   (sff_pkg::COEFS[k]),
            .CENTRE (!sff_pkg::EVEN_TAPS && (k == STAGES - 1))
        ) u_stage (
            .i_clk  (i_core_clk),
            .i_rst  (i_rst),
            .i_adv  (adv),
            .i_head (smp_q[2*k]),
            .i_tail (smp_q[ORDER]),
            .i_acc  (acc[k]),
            .o_acc  (acc[k+1])
        );
    end

    // ==========================================================
    // Rounding or truncation
    if (sff_pkg::ROUND_OPTION) begin : g_round
        logic signed [ACC_W-1:0] rnd_sum_q;
        logic signed [ACC_W-1:0] rnd_q;
        logic signed [ACC_W-1:0] rnd_ref;

        always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
                rnd_sum_q <= '0;
                rnd_q     <= '0;
            end else if (adv) begin
                rnd_sum_q <= acc_last + (acc_last < 0 ? sff_pkg::RND_NEG : sff_pkg::RND_POS);
                rnd_q     <= rnd_sum_q >>> FW;
            end
        end

        assign red     = rnd_q;
        // Half away from zero, written on the magnitude
        assign rnd_ref = (acc_last < 0) ? -((-acc_last + sff_pkg::RND_POS) >>> FW)
                                        : (acc_last + sff_pkg::RND_POS) >>> FW;
        sequence two_adv_s;
            adv ##1 adv;
        endsequence
        round_result_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
            two_adv_s |=> red == $past(rnd_ref, 2))
            else $error("rounded result wrong");
    end else begin : g_trunc
        assign red = acc_last >>> FW;
        trunc_result_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
            (acc_last - (red <<< FW)) >= 0 && (acc_last - (red <<< FW)) < ACC_W'(2 ** FW))
            else $error("truncated result wrong");
    end

    // ==========================================================
    // Saturation or wrap
    if (sff_pkg::SATURATE_OPTION) begin : g_sat
        logic signed [SW-1:0] sat_q;

        always_ff @(posedge i_core_clk) begin
            if (i_rst) begin
                sat_q <= '0;
            end else if (adv) begin
                if (red > ACC_W'(sff_pkg::SAMPLE_MAX)) begin
                    sat_q <= sff_pkg::SAMPLE_MAX;
                end else if (red < ACC_W'(sff_pkg::SAMPLE_MIN)) begin
                    sat_q <= sff_pkg::SAMPLE_MIN;
                end else begin
                    sat_q <= red[SW-1:0];
                end
            end
        end

        assign y_red = sat_q;
        clamp_high_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
            adv && red > ACC_W'(sff_pkg::SAMPLE_MAX) |=> y_red == sff_pkg::SAMPLE_MAX)
            else $error("positive overflow not clamped");
        clamp_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
            adv && red < ACC_W'(sff_pkg::SAMPLE_MIN) |=> y_red == sff_pkg::SAMPLE_MIN)
            else $error("negative overflow not clamped");
    end else begin : g_wrap
        assign y_red = red[SW-1:0];
        wrap_result_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
            (red - ACC_W'(y_red)) % ACC_W'(2 ** SW) == 0)
            else $error("wrapped result wrong");
    end

    // ==========================================================
    // Latency padding and fill tracking
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pad_q <= '{default: '0};
        end else if (adv) begin
            pad_q[0] <= y_red;
            for (int i = 1; i < PAD_LEN; i++) begin
                pad_q[i] <= pad_q[i-1];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fill_q <= '0;
        end else if (adv && fill_q != FILL_W'(LATENCY)) begin
            fill_q <= fill_q + 1'b1;
        end
    end

    assign beat.valid = push;
    assign beat.data  = pad_q[PAD_LEN-1];

    // ==========================================================
    // Output buffer
    sff_fifo #(
        .WIDTH (SW),
        .DEPTH (sff_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (beat.valid),
        .i_in_data   (beat.data),
        .o_in_ready  (o_ready),
        .o_out_valid (o_y_valid),
        .o_out_data  (o_y),
        .i_out_ready (i_y_ready)
    );

    // ==========================================================
    // Checks on the pipeline
    capture_sample_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        adv |=> smp_q[0] == $past(i_x) && smp_q[1] == $past(smp_q[0]))
        else $error("sample not captured on enabled edge");

    idle_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !adv |=> $stable(smp_q[ORDER]) && $stable(acc_last) && $stable(red)
                 && $stable(y_red) && $stable(pad_q[PAD_LEN-1]) && $stable(fill_q))
        else $error("pipeline moved while idle");

    first_output_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        adv && fill_q == FILL_W'(LATENCY) |=> o_y_valid)
        else $error("first output at wrong enabled edge");
    fill_step_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        adv && fill_q < FILL_W'(LATENCY) |=> fill_q == $past(fill_q) + 1'b1 && !$past(push))
        else $error("fill count did not follow enabled edges");
endmodule : sff_filter

/* File: rtl/sff_pkg.sv */
// Constants and types shared by the symmetric FIR filter.
// Assumes build-time configuration only and one core clock.
package sff_pkg;

    // ==========================================================
    // Build options
    localparam int SAMPLE_WIDTH          = 16;
    localparam int COEF_TOTAL_BITS       = 10;
    localparam int COEF_FRACTION_BITS    = 9;
    localparam int TAP_COUNT             = 44;
    localparam bit EVEN_TAPS             = 1'b1;
    localparam bit ROUND_OPTION          = 1'b1;
    localparam bit SATURATE_OPTION       = 1'b1;
    localparam bit NEGATED_PAIRS_OPTION  = 1'b1;
    localparam bit SKIP_NULL_TAPS_OPTION = 1'b1;
    localparam int FIFO_DEPTH            = 8;

    // ==========================================================
    // Derived sizes and latencies
    localparam int ORDER      = TAP_COUNT - 1;
    localparam int STAGES     = (TAP_COUNT + 1) / 2;
    localparam int PRE_W      = SAMPLE_WIDTH + 1;
    localparam int PROD_W     = PRE_W + COEF_TOTAL_BITS;
    localparam int ACC_W      = PROD_W + $clog2(STAGES);
    localparam int MAC_LAT    = 2;
    localparam int RND_LAT    = ROUND_OPTION ? 2 : 0;
    localparam int SAT_LAT    = SATURATE_OPTION ? 1 : 0;
    localparam int EVEN_EXTRA = 4;
    localparam int ODD_EXTRA  = 6;
    localparam int LATENCY    = EVEN_TAPS ? TAP_COUNT / 2 + RND_LAT + SAT_LAT + EVEN_EXTRA
                                          : ORDER / 2 + RND_LAT + SAT_LAT + ODD_EXTRA;
    localparam int CORE_LAT   = STAGES + MAC_LAT + RND_LAT + SAT_LAT;
    localparam int PAD_LEN    = LATENCY - CORE_LAT - 1;

    // ==========================================================
    // Rounding biases and output limits
    localparam logic signed [ACC_W-1:0] RND_POS =
        ACC_W'(COEF_FRACTION_BITS > 0 ? 2 ** (COEF_FRACTION_BITS - 1) : 0);
    localparam logic signed [ACC_W-1:0] RND_NEG =
        ACC_W'(COEF_FRACTION_BITS > 0 ? 2 ** (COEF_FRACTION_BITS - 1) - 1 : 0);
    localparam logic signed [SAMPLE_WIDTH-1:0] SAMPLE_MAX = {1'b0, {(SAMPLE_WIDTH-1){1'b1}}};
    localparam logic signed [SAMPLE_WIDTH-1:0] SAMPLE_MIN = {1'b1, {(SAMPLE_WIDTH-1){1'b0}}};

    // ==========================================================
    // Half of the tap weights, index k pairs with ORDER-k
    localparam logic signed [COEF_TOTAL_BITS-1:0] COEFS [STAGES] = '{
        10'h000, 10'h001, 10'h3ff, 10'h000, 10'h003, 10'h3fb, 10'h000, 10'h009,
        10'h3f3, 10'h000, 10'h012, 10'h3e6, 10'h000, 10'h024, 10'h3cc, 10'h000,
        10'h04a, 10'h391, 10'h000, 10'h0c8, 10'h2d0, 10'h100};

    // ==========================================================
    // Result beat handed to the output buffer
    typedef struct packed {
        logic                           valid;
        logic signed [SAMPLE_WIDTH-1:0] data;
    } sff_beat_type;

endpackage : sff_pkg

/* File: sim/sff_sink_model.sv */
// Downstream sample consumer facing the filter output buffer.
// Assumes the core clock and a mode input from the testbench.
`timescale 1ns/100ps

// ==========================================================
// Consumer: mode 0 always ready, 1 stalled, 2 ready one cycle in three
module sff_sink_model (
    input  wire logic       i_clk,     // Core clock
    input  wire logic       i_rst,     // Sync reset
    input  wire logic [1:0] i_mode,    // Acceptance pattern
    output logic            o_y_ready  // Takes the head sample
);
    logic [1:0] phase;

    initial begin
        phase     = 2'h0;
        o_y_ready = 1'b1;
    end

    // Changes just after the edge, like any real consumer register
    always @(posedge i_clk) begin
        #1;
        phase = (i_rst || phase == 2'h2) ? 2'h0 : phase + 2'h1;
        case (i_mode)
            2'h0:    o_y_ready = 1'b1;
            2'h1:    o_y_ready = 1'b0;
            default: o_y_ready = (phase == 2'h0);
        endcase
    end
endmodule : sff_sink_model

/* File: sim/symmetric_fir_filter_tb.sv */
// Self-checking bench for the symmetric FIR filter top.
// Assumes the build options of sff_pkg and the sink model beside it.
`timescale 1ns/100ps

module symmetric_fir_filter_tb;
    localparam int SW = sff_pkg::SAMPLE_WIDTH;
    localparam int FB = sff_pkg::COEF_FRACTION_BITS;

    logic                 i_core_clk;
    logic                 i_rst;
    logic                 i_en;
    logic signed [SW-1:0] i_x;
    logic                 o_ready;
    logic signed [SW-1:0] o_y;
    logic                 o_y_valid;
    logic                 o_y_ready;
    logic [1:0]           cons_mode;
    int                   n_fail;
    int                   checks_done;
    int                   n_adv;
    int                   sat_hits;
    longint               hist [sff_pkg::TAP_COUNT];
    logic signed [SW-1:0] exp_q [$];
    logic signed [SW-1:0] pend_q [$];
    logic                 adv_q;
    logic                 hold_q;
    logic signed [SW-1:0] x_q;
    logic signed [SW-1:0] held_y;

    // ==========================================================
    // Clock, design and consumer
    initial i_core_clk = 1'b0;
    always #4 i_core_clk = ~i_core_clk;

    sff_filter dut_u (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_en       (i_en),
        .i_x        (i_x),
        .o_ready    (o_ready),
        .o_y        (o_y),
        .o_y_valid  (o_y_valid),
        .i_y_ready  (o_y_ready)
    );

    sff_sink_model sink_u (
        .i_clk     (i_core_clk),
        .i_rst     (i_rst),
        .i_mode    (cons_mode),
        .o_y_ready (o_y_ready)
    );

    // ==========================================================
    // Reference filter
    function automatic logic signed [SW-1:0] ref_out();
        longint acc;
        longint h;
        begin
            acc = 0;
            for (int k = 0; k < sff_pkg::TAP_COUNT; k++) begin
                if (k < sff_pkg::STAGES)
                    h = sff_pkg::COEFS[k];
                else if (sff_pkg::NEGATED_PAIRS_OPTION)
                    h = -longint'(sff_pkg::COEFS[sff_pkg::ORDER - k]);
                else
                    h = sff_pkg::COEFS[sff_pkg::ORDER - k];
                acc = acc + h * hist[k];
            end
            if (sff_pkg::ROUND_OPTION)
                acc = acc + ((acc >= 0) ? (64'sd1 <<< (FB - 1)) : (64'sd1 <<< (FB - 1)) - 1);
            acc = acc >>> FB;
            if (sff_pkg::SATURATE_OPTION && acc > longint'(sff_pkg::SAMPLE_MAX))
                acc = sff_pkg::SAMPLE_MAX;
            if (sff_pkg::SATURATE_OPTION && acc < longint'(sff_pkg::SAMPLE_MIN))
                acc = sff_pkg::SAMPLE_MIN;
            ref_out = SW'(acc);
        end
    endfunction : ref_out

    function automatic logic signed [SW-1:0] gen(input int kind, input int i);
        case (kind)
            0:       gen = (i == 0) ? 16'h4000 : 16'h0000;
            1:       gen = (i == 0) ? 16'hff00 : (i < 46) ? 16'h0000 : SW'(i * 291 - 20480);
            2:       gen = i[0] ? 16'h8000 : 16'h7fff;
            default: gen = SW'(i * 273);
        endcase
    endfunction : gen

    // ==========================================================
    // Reporting
    task automatic miss(input string msg);
        n_fail++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask : miss

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // ==========================================================
    // Monitor: decisions for the coming edge are taken mid-cycle
    always @(negedge i_core_clk) begin
        if (!i_rst) begin
            checks_done++;
            if (o_y_valid !== (exp_q.size() != 0)) miss("valid flag");
            if (hold_q && o_y !== held_y) miss("stalled output moved");
            if (exp_q.size() < 8 && o_ready !== 1'b1) miss("ready low early");
            if (o_y_valid && o_y_ready) begin
                checks_done++;
                if (exp_q.size() == 0 || o_y !== exp_q[0]) miss("sample value");
                if (exp_q.size() != 0) void'(exp_q.pop_front());
            end
            hold_q = o_y_valid && !o_y_ready;
            held_y = o_y;
            adv_q  = i_en && o_ready;
            x_q    = i_x;
        end else begin
            hold_q = 1'b0;
            adv_q  = 1'b0;
        end
    end

    always @(posedge i_core_clk) begin
        if (adv_q) begin
            for (int k = sff_pkg::TAP_COUNT - 1; k > 0; k--) hist[k] = hist[k-1];
            hist[0] = x_q;
            n_adv++;
            // Result of the oldest sample leaves once the pipe is full
            pend_q.push_back(ref_out());
            if (n_adv > sff_pkg::LATENCY) begin
                exp_q.push_back(pend_q.pop_front());
                if (exp_q[$] == sff_pkg::SAMPLE_MAX || exp_q[$] == sff_pkg::SAMPLE_MIN)
                    sat_hits++;
            end
        end
    end

    // ==========================================================
    // Source tasks, all driving 1 ns after the edge
    task automatic send(input logic signed [SW-1:0] x);
        logic ok;
        int   n;
        i_en = 1'b1;
        i_x  = x;
        n    = 0;
        ok   = 1'b0;
        while (!ok && n < 100) begin
            @(negedge i_core_clk);
            ok = (o_ready === 1'b1);
            @(posedge i_core_clk);
            #1;
            n++;
        end
        if (!ok) miss("sample never taken");
    endtask : send

    task automatic idle(input int n);
        i_en = 1'b0;
        i_x  = ~i_x;
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : idle

    task automatic play(input int kind, input int n, input int gap, input logic [1:0] mode);
        cons_mode = mode;
        for (int i = 0; i < n; i++) begin
            send(gen(kind, i));
            if (gap > 0) idle(gap);
        end
        cons_mode = 2'h0;
        idle(90);
        checks_done++;
        if (exp_q.size() != 0) miss("outputs missing after drain");
    endtask : play

    task automatic reset_run(input int n);
        i_rst = 1'b1;
        exp_q.delete();
        pend_q.delete();
        for (int k = 0; k < sff_pkg::TAP_COUNT; k++) hist[k] = 0;
        n_adv = 0;
        repeat (n) @(posedge i_core_clk);
        #1;
        checks_done++;
        if (o_ready !== 1'b1 || o_y_valid !== 1'b0 || o_y !== 16'h0000) miss("reset state");
        i_rst = 1'b0;
    endtask : reset_run

    // ==========================================================
    // Tests
    initial begin
        i_rst = 1'b1;
        i_en = 1'b0;
        i_x = 16'h0000;
        cons_mode = 2'h0;
        n_fail = 0;
        checks_done = 0;
        sat_hits = 0;
        hold_q = 1'b0;
        adv_q = 1'b0;
        @(posedge i_core_clk);
        #1;
        reset_run(6);
        play(0, 50, 0, 2'h0);
        play(1, 90, 1, 2'h2);
        reset_run(2);
        play(2, 100, 0, 2'h0);
        checks_done++;
        if (sat_hits == 0) miss("no clamped output reached");
        cons_mode = 2'h1;
        fork
            begin
                for (int i = 0; i < 45; i++) send(gen(3, i));
            end
            begin : fill_watch
                int n;
                n = 0;
                while (o_ready !== 1'b0 && n < 200) begin
                    @(negedge i_core_clk);
                    n++;
                end
                checks_done++;
                if (exp_q.size() < 8 || exp_q.size() > 10) miss("buffer fill level");
                repeat (10) @(negedge i_core_clk);
                checks_done++;
                if (o_ready !== 1'b0) miss("ready rose while stalled");
                @(posedge i_core_clk);
                #1;
                cons_mode = 2'h0;
            end
        join
        play(3, 0, 0, 2'h0);
        conclude();
    end

    initial begin
        #100000;
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : symmetric_fir_filter_tb
